/* design/smc_consts.vh */
// Purpose: constants of the standby mode controller
// Assumes: 8-bit registers in the low byte of aligned AHB-Lite words
// Notes:   included by smc_standby_ctrl.v and smc_wdt_tick.v
//
// Behaviour
// [R1] halt with standby_select set enters standby
// [R2] standby stops cpu, clock, supporting modules
// [R3] cpu registers and ram kept in standby
// [R4] ports held or floated per port_float_select
// [R5] entry keeps controller and port registers
// [R6] entry clears dma, timer, converter registers
// [R7] entry clears watchdog bits 7-5, reset status
// [R8] entry clears all serial interface registers
// [R9] exit only by nmi, power-on, manual reset
// [R10] selected nmi edge restarts oscillator, watchdog clock
// [R11] watchdog overflow ends settling, nmi handling starts
// [R12] software sets interval not below settling time
// [R13] nmi driver holds proper level around standby
// [R14] reset low with nmi high: power-on reset
// [R15] rising nmi for power-on reset does not wake
// [R16] reset low with nmi low: manual reset
// [R17] falling nmi before manual reset wakes first
// [R18] handler may select rising edge, then halt
// [R19] standby_select refused while watchdog runs
// [R20] port_float_select one floats ports in standby
// [R21] reset during settling abandons nmi wake
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SMC_ADDR_STBY   8'h00
`define SMC_ADDR_IRQC   8'h04
`define SMC_ADDR_WCS    8'h08
`define SMC_ADDR_WCNT   8'h0C
`define SMC_ADDR_WRS    8'h10
`define SMC_ADDR_CTL    8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SMC_STBY_SEL    7
`define SMC_STBY_FLOAT  6
`define SMC_IRQC_EDGE   0
`define SMC_WCS_OVER    7
`define SMC_WCS_MODE    6
`define SMC_WCS_RUN     5
`define SMC_CTL_FFALL   0

// ----------------------------------------------------------------
// reset values and fixed bits
// ----------------------------------------------------------------
`define SMC_STBY_RST    8'h1F
`define SMC_STBY_ONES   8'h1F
`define SMC_IRQC_RST    8'h00
`define SMC_WCS_RST     8'h18
`define SMC_WCS_ONES    8'h18
`define SMC_WCNT_RST    8'h00
`define SMC_WRS_RST     8'h1F
`define SMC_CTL_RST     8'h01

// ----------------------------------------------------------------
// timing: prescale widens by this many bits per clock-select step
// ----------------------------------------------------------------
`define SMC_PRE_STEP    2
`define SMC_PRE_W       16

`endif

/* design/smc_wdt_tick.v */
// Purpose: watchdog prescaler, one tick per selected interval
// Assumes: run low clears the prescale count
// Notes:   interval is 2**(sel*STEP+1) clocks
`timescale 1ns/1ps
`include "smc_consts.vh"

module smc_wdt_tick #(
	parameter STEP = `SMC_PRE_STEP,
	parameter W    = `SMC_PRE_W
) (
	// clock and reset
	input  wire       hclk,
	input  wire       hresetn,
	// control
	input  wire       run,
	input  wire [2:0] sel,
	// result
	output reg        tick
);

	reg  [W-1:0] cnt_r;
	wire [W-1:0] mask;
	wire [4:0]   top;

	assign top = sel * STEP[4:0];

	// ----------------------------------------------------------------
	// per-bit mask of the prescale count
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_mask
			assign mask[i] = (i <= top);
		end
	endgenerate

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= {W{1'b0}};
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_r <= {W{1'b0}};
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= ((cnt_r & mask) == mask);
		end
	end

endmodule // smc_wdt_tick

/* design/smc_standby_ctrl.v */
// Purpose: standby entry, hold and wake sequencing with its registers
// Assumes: pins nmi_pin and chip_clear_pin_n are asynchronous
// Notes:   hclk itself never stops; enables gate the chip clocks
`timescale 1ns/1ps
`include "smc_consts.vh"

module smc_standby_ctrl (
	// clock and reset
	input  wire        hclk,
	input  wire        hresetn,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	// cpu side
	input  wire        halt_exec,
	// pins
	input  wire        nmi_pin,
	input  wire        chip_clear_pin_n,
	// clock control
	output wire        cpu_clk_en,
	output wire        periph_clk_en,
	output wire        wdt_clk_en,
	output wire        osc_en,
	output wire        cpu_retain,
	// ports
	output wire        io_hold,
	output wire        io_float,
	// supporting module clears
	output reg         clr_dma,
	output reg         clr_timer,
	output reg         clr_adc,
	output reg         clr_serial,
	// exits
	output reg         nmi_wake,
	output reg         por_req,
	output reg         manual_reset_req,
	// status
	output wire        standby_active,
	output wire        nmi_edge_select
);

	localparam [2:0] ST_RUN    = 3'b001;
	localparam [2:0] ST_STBY   = 3'b010;
	localparam [2:0] ST_SETTLE = 3'b100;

	reg  [2:0]  st_r;
	reg  [2:0]  st_nxt;
	reg  [7:0]  stby_r;
	reg  [7:0]  irqc_r;
	reg  [7:0]  wcs_r;
	reg  [7:0]  wcnt_r;
	reg  [7:0]  wrs_r;
	reg  [7:0]  ctl_r;
	reg  [7:0]  rdata_r;
	reg  [7:0]  ap_addr_r;
	reg         ap_wr_r;
	reg         nmi_s1_r;
	reg         nmi_s2_r;
	reg         nmi_s3_r;
	reg         rst_s1_r;
	reg         rst_s2_r;
	reg  [7:0]  rd_mux;
	wire        ap_take;
	wire [7:0]  wd;
	wire        st_run;
	wire        st_stby;
	wire        st_settle;
	wire        wdt_tick;
	wire        wdt_ovf;
	wire        nmi_fall;
	wire        nmi_rise;
	wire        wake_rise;
	wire        wake_edge;
	wire        pin_reset;
	wire        enter;
	wire        wr_stby;
	wire        wr_irqc;
	wire        wr_wcs;
	wire        wr_wcnt;
	wire        wr_wrs;
	wire        wr_ctl;

	assign st_run    = st_r[0];
	assign st_stby   = st_r[1];
	assign st_settle = st_r[2];

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_s1_r <= 1'b1;
			nmi_s2_r <= 1'b1;
			nmi_s3_r <= 1'b1;
			rst_s1_r <= 1'b1;
			rst_s2_r <= 1'b1;
		end else begin
			nmi_s1_r <= nmi_pin;
			nmi_s2_r <= nmi_s1_r;
			nmi_s3_r <= nmi_s2_r;
			rst_s1_r <= chip_clear_pin_n;
			rst_s2_r <= rst_s1_r;
		end
	end

	assign nmi_fall  = nmi_s3_r & ~nmi_s2_r;
	assign nmi_rise  = ~nmi_s3_r & nmi_s2_r;
	// edge detection is forced to falling in standby unless ctl clears it
	assign wake_rise = irqc_r[`SMC_IRQC_EDGE] & ~ctl_r[`SMC_CTL_FFALL]; // [R15] [R17]
	assign wake_edge = wake_rise ? nmi_rise : nmi_fall; // [R10] [R13]
	assign pin_reset = ~rst_s2_r;

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	assign ap_take   = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = {24'h000000, rdata_r};
	assign wd        = hwdata[7:0];
	assign wr_stby   = ap_wr_r & (ap_addr_r == `SMC_ADDR_STBY);
	assign wr_irqc   = ap_wr_r & (ap_addr_r == `SMC_ADDR_IRQC);
	assign wr_wcs    = ap_wr_r & (ap_addr_r == `SMC_ADDR_WCS);
	assign wr_wcnt   = ap_wr_r & (ap_addr_r == `SMC_ADDR_WCNT);
	assign wr_wrs    = ap_wr_r & (ap_addr_r == `SMC_ADDR_WRS);
	assign wr_ctl    = ap_wr_r & (ap_addr_r == `SMC_ADDR_CTL);

	always @* begin
		if (haddr[7:0] == `SMC_ADDR_STBY) begin
			rd_mux = stby_r;
		end else if (haddr[7:0] == `SMC_ADDR_IRQC) begin
			rd_mux = irqc_r;
		end else if (haddr[7:0] == `SMC_ADDR_WCS) begin
			rd_mux = wcs_r;
		end else if (haddr[7:0] == `SMC_ADDR_WCNT) begin
			rd_mux = wcnt_r;
		end else if (haddr[7:0] == `SMC_ADDR_WRS) begin
			rd_mux = wrs_r;
		end else if (haddr[7:0] == `SMC_ADDR_CTL) begin
			rd_mux = ctl_r;
		end else begin
			rd_mux = 8'h00;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r   <= 1'b0;
			ap_addr_r <= 8'h00;
			rdata_r   <= 8'h00;
		end else begin
			ap_wr_r <= ap_take & hwrite;
			if (ap_take) begin
				ap_addr_r <= haddr[7:0];
			end
			if (ap_take & ~hwrite) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog prescaler and overflow
	// ----------------------------------------------------------------
	smc_wdt_tick u_tick (
		.hclk    (hclk),
		.hresetn (hresetn),
		.run     ((st_run & wcs_r[`SMC_WCS_RUN]) | st_settle),
		.sel     (wcs_r[2:0]),
		.tick    (wdt_tick)
	);

	assign wdt_ovf = wdt_tick & (wcnt_r == 8'hFF);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign enter = st_run & halt_exec & stby_r[`SMC_STBY_SEL]; // [R1]

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_RUN: begin
				if (enter) begin
					st_nxt = ST_STBY;
				end
			end
			ST_STBY: begin
				if (pin_reset) begin // [R9] [R14] [R16]
					st_nxt = ST_RUN;
				end else if (wake_edge) begin
					st_nxt = ST_SETTLE; // [R10]
				end
			end
			ST_SETTLE: begin
				if (pin_reset) begin // [R21]
					st_nxt = ST_RUN;
				end else if (wdt_ovf) begin
					st_nxt = ST_RUN; // [R11] [R12]
				end
			end
			default: begin
				st_nxt = ST_RUN;
			end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r             <= ST_RUN;
			nmi_wake         <= 1'b0;
			por_req          <= 1'b0;
			manual_reset_req <= 1'b0;
			clr_dma          <= 1'b0;
			clr_timer        <= 1'b0;
			clr_adc          <= 1'b0;
			clr_serial       <= 1'b0;
		end else begin
			st_r             <= st_nxt;
			nmi_wake         <= st_settle & ~pin_reset & wdt_ovf; // [R11]
			por_req          <= ~st_run & pin_reset & nmi_s2_r; // [R14] [R21]
			manual_reset_req <= ~st_run & pin_reset & ~nmi_s2_r; // [R16] [R21]
			clr_dma          <= enter; // [R6]
			clr_timer        <= enter; // [R6]
			clr_adc          <= enter; // [R6]
			clr_serial       <= enter; // [R8]
		end
	end

	// ----------------------------------------------------------------
	// registers; only the watchdog ones change on entry
	// ----------------------------------------------------------------
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stby_r <= `SMC_STBY_RST;
			irqc_r <= `SMC_IRQC_RST;
			wcs_r  <= `SMC_WCS_RST;
			wcnt_r <= `SMC_WCNT_RST;
			wrs_r  <= `SMC_WRS_RST;
			ctl_r  <= `SMC_CTL_RST;
		end else begin
			if (wr_stby) begin
				if (!wcs_r[`SMC_WCS_RUN] || !wd[`SMC_STBY_SEL]) begin // [R19]
					stby_r[`SMC_STBY_SEL] <= wd[`SMC_STBY_SEL];
				end
				if (!wcs_r[`SMC_WCS_RUN] || !wd[`SMC_STBY_FLOAT]) begin
					stby_r[`SMC_STBY_FLOAT] <= wd[`SMC_STBY_FLOAT]; // [R20]
				end
			end
			if (wr_irqc) begin
				irqc_r <= {7'h00, wd[`SMC_IRQC_EDGE]}; // [R18]
			end
			if (wr_ctl) begin
				ctl_r <= {7'h00, wd[`SMC_CTL_FFALL]};
			end
			if (wr_wrs) begin
				wrs_r <= wd;
			end
			if (enter) begin
				// clock select and count stay for the wake interval
				wcs_r <= {3'b000, wcs_r[4:0]} | `SMC_WCS_ONES; // [R7]
				wrs_r <= `SMC_WRS_RST; // [R7]
			end else begin
				if (wr_wcs) begin
					wcs_r <= {wd[7:5] & {wcs_r[`SMC_WCS_OVER], 2'b11}, 2'b11, wd[2:0]};
				end
				if (st_run & wcs_r[`SMC_WCS_RUN] & wdt_ovf) begin
					wcs_r[`SMC_WCS_OVER] <= 1'b1;
				end
			end
			if (wr_wcnt & st_run) begin
				wcnt_r <= wd;
			end else if (wdt_tick) begin
				wcnt_r <= wcnt_r + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// clock, hold and port control
	// ----------------------------------------------------------------
	assign cpu_clk_en      = st_run; // [R2]
	assign periph_clk_en   = st_run; // [R2] [R5]
	assign wdt_clk_en      = st_run | st_settle; // [R10]
	assign osc_en          = ~st_stby; // [R10]
	assign cpu_retain      = ~st_run; // [R3]
	assign io_float        = ~st_run & stby_r[`SMC_STBY_FLOAT]; // [R4] [R20]
	assign io_hold         = ~st_run & ~stby_r[`SMC_STBY_FLOAT]; // [R4]
	assign standby_active  = ~st_run;
	assign nmi_edge_select = irqc_r[`SMC_IRQC_EDGE];

endmodule // smc_standby_ctrl

/* verification/smc_standby_checker.sv */
// Purpose: port checks of the standby controller
// Assumes: one clock hclk, hresetn async active low
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module smc_standby_checker (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// clock control
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic wdt_clk_en,
	input wire logic osc_en,
	input wire logic cpu_retain,
	// ports
	input wire logic io_hold,
	input wire logic io_float,
	// clears and exits
	input wire logic clr_dma,
	input wire logic clr_timer,
	input wire logic clr_adc,
	input wire logic clr_serial,
	input wire logic nmi_wake,
	input wire logic por_req,
	input wire logic manual_reset_req,
	input wire logic standby_active
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_clears;
		clr_dma && clr_timer && clr_adc && clr_serial ##1 !clr_dma && !clr_serial;
	endsequence
	sequence s_exit;
		##[0:2] (nmi_wake || por_req || manual_reset_req);
	endsequence
	a_entry_clears: assert property ($rose(standby_active) |-> s_clears)
		else $error("entry clears missing");
	a_entry_stops: assert property ($rose(standby_active) |-> !cpu_clk_en && !periph_clk_en && cpu_retain)
		else $error("entry did not stop clocks");
	a_port_choice: assert property (cpu_retain |-> io_hold != io_float)
		else $error("port state wrong in standby");
	a_run_ports: assert property (cpu_clk_en |-> !io_hold && !io_float && !cpu_retain)
		else $error("ports not free in run");
	a_settle_clock: assert property (standby_active && osc_en |-> wdt_clk_en && !periph_clk_en)
		else $error("settling clock wrong");
	a_standby_dark: assert property (standby_active && !osc_en |-> !wdt_clk_en && !cpu_clk_en)
		else $error("clock runs in standby");
	a_exit_cause: assert property ($fell(standby_active) |-> s_exit)
		else $error("standby left without cause");
	a_one_exit: assert property ($onehot0({nmi_wake, por_req, manual_reset_req}))
		else $error("two exits at once");
	a_wake_runs: assert property (nmi_wake |-> cpu_clk_en && !standby_active)
		else $error("wake without run");
endmodule // smc_standby_checker

/* verification/smc_pin_model.sv */
// Purpose: external nmi and reset pin drivers
// Assumes: requests change just after a clock edge
// Notes:   slow adds pin skew within one cycle
`timescale 1ns/1ps
module smc_pin_model (
	// requests
	input  wire logic nmi_req,
	input  wire logic clr_req,
	input  wire logic slow,
	// pins
	output logic      nmi_pin = 1'b1,
	output logic      chip_clear_pin_n = 1'b1
);
	always @(nmi_req) nmi_pin <= #(slow ? 13 : 3) nmi_req;
	always @(clr_req) chip_clear_pin_n <= #(slow ? 13 : 3) !clr_req;
endmodule // smc_pin_model

/* verification/standby_mode_controller_tb.sv */
// Purpose: self-checking bench of the standby controller
// Assumes: ahb-lite single word transfers, zero wait slave
// Notes:   reads and exit pulses checked from queues
`timescale 1ns/1ps
module standby_mode_controller_tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, halt_exec = 0;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2, cks;
	logic        nmi_req = 1, clr_req = 0, slow = 0, rph = 0;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, nmi_pin, chip_clear_pin_n, cpu_clk_en, periph_clk_en;
	wire         wdt_clk_en, osc_en, cpu_retain, io_hold, io_float, clr_dma, clr_timer;
	wire         clr_adc, clr_serial, nmi_wake, por_req, manual_reset_req, standby_active;
	wire         nmi_edge_select;
	wire  [3:0]  ev = {nmi_wake, por_req, manual_reset_req, clr_serial};
	int          fail_count = 0, compares = 0;
	logic [31:0] rq[$];
	logic [3:0]  eq[$];
	logic [7:0]  rv[7] = '{8'h1F, 8'h00, 8'h18, 8'h00, 8'h1F, 8'h01, 8'h00};
	always #10 hclk = ~hclk;
	smc_standby_ctrl u_dut (.*, .hready(hreadyout));
	smc_pin_model u_pins (.*);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task wait_ev(input logic [3:0] m, input int lim);
		int n;
		n = 0;
		while ((ev & m) == 4'h0 && n < lim) begin
			@(posedge hclk);
			n++;
		end
		if ((ev & m) == 4'h0) begin
			fail_count++;
			print_verdict;
		end
	endtask
	task hwait;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			print_verdict;
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		hwait;
		htrans <= 2'b00;
		hsel <= 1'b0;
		if (w)
			hwdata <= d;
		else begin
			rq.push_back(d);
			rph <= 1'b1;
		end
		hwait;
		rph <= 1'b0;
	endtask
	task halt_pulse;
		@(posedge hclk) halt_exec <= 1'b1;
		@(posedge hclk) halt_exec <= 1'b0;
	endtask
	task enter;
		eq.push_back(4'h1);
		halt_pulse;
		wait_ev(4'h1, 5);
	endtask
	task rst_pin(input logic [3:0] m);
		eq.push_back(m);
		clr_req <= 1'b1;
		wait_ev(m, 12);
		clr_req <= 1'b0;
		repeat (4) @(posedge hclk);
	endtask
	// --------------------------------------------------------
	// result monitor
	// --------------------------------------------------------
	always @(posedge hclk) begin
		if (rph && hreadyout) begin
			chk(hrdata, rq.pop_front());
			chk(hresp, 1'b0);
		end
		if (|ev)
			chk(ev, eq.size() ? eq.pop_front() : 4'h0);
	end
	initial begin
		void'($urandom(32'h0F4C));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			xfer(1'b0, 8'(4 * i), {24'h0, rv[i]});
		$display("test reset values done");
		xfer(1'b1, 8'h08, 32'h20);
		xfer(1'b1, 8'h00, 32'hC0);
		xfer(1'b0, 8'h00, 32'h1F);
		halt_pulse;
		repeat (3) @(posedge hclk);
		chk(standby_active, 1'b0);
		$display("test refusal done");
		for (int e = 0; e < 2; e++) begin
			cks = 3'($urandom % 2);
			slow <= e[0];
			nmi_req <= !e[0];
			xfer(1'b1, 8'h08, {29'h0, cks});
			xfer(1'b1, 8'h14, {31'h0, !e[0]});
			xfer(1'b1, 8'h04, 32'(e));
			xfer(1'b1, 8'h10, 32'h05);
			xfer(1'b1, 8'h00, 32'h80);
			enter;
			chk({cpu_clk_en, io_hold, io_float, osc_en}, 4'b0100);
			eq.push_back(4'h8);
			nmi_req <= e[0];
			wait_ev(4'h8, 256 * (2 << (2 * cks)) + 40);
			xfer(1'b0, 8'h10, 32'h1F);
			xfer(1'b0, 8'h08, 32'h18 | cks);
			xfer(1'b0, 8'h04, 32'(e));
			chk(nmi_edge_select, e[0]);
			$display("test nmi wake %0d done", e);
		end
		// settle the pin low in run so that entry sees no fresh edge
		nmi_req <= 1'b0;
		xfer(1'b1, 8'h14, 32'h01);
		xfer(1'b1, 8'h00, 32'hC0);
		enter;
		chk({io_hold, io_float}, 2'b01);
		nmi_req <= 1'b1;
		repeat (10) @(posedge hclk);
		chk({standby_active, osc_en}, 2'b10);
		rst_pin(4'h4);
		$display("test power-on exit done");
		xfer(1'b1, 8'h08, 32'h02);
		enter;
		nmi_req <= 1'b0;
		repeat (6) @(posedge hclk);
		chk({standby_active, osc_en, cpu_clk_en}, 3'b110);
		rst_pin(4'h2);
		$display("test manual exit done");
		chk(eq.size(), 0);
		print_verdict;
	end
endmodule // standby_mode_controller_tb
bind smc_standby_ctrl smc_standby_checker u_chk (.*);
